// file: hw/mscan_cfg.svh
// Constants for the monitor scan timing block
`ifndef MSCAN_CFG_SVH
`define MSCAN_CFG_SVH

// Clock rate in kHz
`define MSCAN_CLK_KHZ       25000
// Times in nanoseconds as printed
`define MSCAN_T_VOLT_NS     10600
`define MSCAN_T_TEMP_NS     46000
`define MSCAN_T_PU00_NS     20000
`define MSCAN_T_PU01_NS     40000
`define MSCAN_T_WAIT_LIM_NS 80000
`define MSCAN_T_WAIT_UNIT_NS 1000
// Cycle counts, rounded up
`define MSCAN_CYC(ns)       (((ns) * `MSCAN_CLK_KHZ + 999999) / 1000000)
`define MSCAN_CYC_VOLT      `MSCAN_CYC(`MSCAN_T_VOLT_NS)
`define MSCAN_CYC_TEMP      `MSCAN_CYC(`MSCAN_T_TEMP_NS)
`define MSCAN_CYC_PU00      `MSCAN_CYC(`MSCAN_T_PU00_NS)
`define MSCAN_CYC_PU01      `MSCAN_CYC(`MSCAN_T_PU01_NS)
`define MSCAN_CYC_US        `MSCAN_CYC(`MSCAN_T_WAIT_UNIT_NS)

// Register offsets
`define MSCAN_A_SETUP       4'h0
`define MSCAN_A_ENABLE      4'h1
`define MSCAN_A_INCFG       4'h2
`define MSCAN_A_ALARM       4'h3
`define MSCAN_A_WAIT        4'h4
`define MSCAN_A_STATUS      4'h5
`define MSCAN_A_CHSEL       4'h6
`define MSCAN_A_DATA        4'h7
`define MSCAN_A_UPPER       4'h8
`define MSCAN_A_LOWER       4'h9
`define MSCAN_A_CHCFG       4'ha
`define MSCAN_A_RESULT      4'hb

// Reset values
`define MSCAN_RST_SETUP     8'h00
`define MSCAN_RST_ENABLE    10'h3ff
`define MSCAN_RST_INCFG     12'h000
`define MSCAN_RST_ALARM     24'h000000
`define MSCAN_RST_DATA      10'h200
`define MSCAN_RST_UPPER     10'h3ff
`define MSCAN_RST_LOWER     10'h000
`define MSCAN_RST_CHCFG     8'h00
`define MSCAN_RST_WAIT      10'h000

// Setup fields
`define MSCAN_SETUP_SCAN    0
`define MSCAN_SETUP_REF_LO  1
`define MSCAN_SETUP_REF_HI  2
`define MSCAN_SETUP_MANUAL  3
// Channel count and index of first external input
`define MSCAN_NCH           10
`define MSCAN_EXT0          2

`endif

// file: hw/mscan_pkg.sv
// Types of the monitor scan timing block
package mscan_pkg;
   typedef enum logic [2:0] {
      MSCAN_IDLE = 3'b000,
      MSCAN_PICK = 3'b001,
      MSCAN_PWUP = 3'b010,
      MSCAN_CONV = 3'b011,
      MSCAN_WAIT = 3'b100
   } mscan_state_e;
   typedef logic [9:0] mscan_code_t;
endpackage : mscan_pkg

// file: hw/mscan_conv_if.sv
// Handshake between sequencer and conversion timer
`timescale 1ns/1ps
interface mscan_conv_if;
   logic        start;
   logic [15:0] cycles;
   logic        done;
   modport seq (output start, output cycles, input done);
   modport tmr (input start, input cycles, output done);
endinterface : mscan_conv_if

// file: hw/mscan_timer.sv
// Cycle down-counter for conversion and power-up delays
`timescale 1ns/1ps
module mscan_timer (
   // Clock and reset
   input  wire logic    clk_i,
   input  wire logic    sys_rst_i,
   // Sequencer side
   mscan_conv_if.tmr    cif
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic        busy_ff;
   logic        nxt_busy;

   // Load on start, count to one, pulse done
   assign nxt_cnt  = cif.start ? cif.cycles : (busy_ff ? cnt_ff - 16'h0001 : cnt_ff);
   assign nxt_busy = cif.start ? 1'b1 : (busy_ff && cnt_ff != 16'h0001);
   assign cif.done = busy_ff && cnt_ff == 16'h0001;

   // Internal clock only, so timing never follows the serial clock
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_ff  <= 16'h0000;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   a_done_after_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      busy_ff && cnt_ff == 16'h0002 && !cif.start |-> !cif.done ##1 cif.done)
      else $error("timer done not one cycle after count two");
endmodule : mscan_timer

// file: hw/mscan_code.sv
// Result coding and threshold compare
`timescale 1ns/1ps
`include "mscan_cfg.svh"
module mscan_code (
   // Raw sample
   input  wire logic [9:0] raw_i,
   input  wire logic       temp_i,
   // Thresholds
   input  wire logic [9:0] upper_i,
   input  wire logic [9:0] lower_i,
   // Coded result and trips
   output logic [9:0]      code_o,
   output logic            over_o,
   output logic            under_o
);
   // Binary code, step of reference over 1024; temperature is signed half degrees
   assign code_o  = raw_i;
   // Reset limits switch a compare off; signed 3ff would trip every warm result
   // Limitation: a temperature lower limit of exactly zero is also off
   wire up_off = upper_i == `MSCAN_RST_UPPER;
   wire lo_off = lower_i == `MSCAN_RST_LOWER;
   // Temperature compares signed, voltage unsigned
   assign over_o  = !up_off && (temp_i ? ($signed(raw_i) > $signed(upper_i)) : (raw_i > upper_i));
   assign under_o = !lo_off && (temp_i ? ($signed(raw_i) < $signed(lower_i)) : (raw_i < lower_i));
endmodule : mscan_code

// file: hw/mscan_top.sv
// Scan sequencer and register file of the system monitor converter
//
// Overview of operation
// - Reset clears input configuration to single-ended voltage
// - Reset clears whole alarm register
// - Reset loads every data register with 0x200
// - Reset sets upper thresholds to 0x3ff
// - Reset sets lower thresholds to zero
// - Reset clears channel configuration registers
// - Voltage takes 10.6 us, temperature 46 us
// - Differential pair is one scan slot
// - Reference power-up delay depends on mode
// - Scan period sums power-up, conversions, wait
// - Conversions timed from internal clock only
// - Reference shuts down in mode 00, 01 long wait
// - Results binary, fixed step per type
// - Unipolar step is reference over 1024
// - Temperature is 10-bit two's complement
// - Scan order internal temp, supply, inputs ascending
`timescale 1ns/1ps
`include "mscan_cfg.svh"
module mscan_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   // Analog front end
   input  wire logic [9:0]  afe_sample_i,
   output logic [3:0]       afe_chan_o,
   output logic             afe_temp_o,
   output logic             afe_diff_o,
   output logic             afe_conv_o,
   output logic             ref_on_o,
   // Scan status
   output logic             scan_end_o,
   output logic             alarm_o
);
   localparam int NCH = `MSCAN_NCH;

   // Registers
   logic [7:0]  setup_ff;
   logic [9:0]  enable_ff;
   logic [11:0] incfg_ff;
   logic [23:0] alarm_ff;
   logic [9:0]  wait_ff;
   logic [3:0]  chsel_ff;
   logic [9:0]  data_ff  [NCH];
   logic [9:0]  upper_ff [NCH];
   logic [9:0]  lower_ff [NCH];
   logic [7:0]  chcfg_ff [NCH];
   logic [31:0] rdata_ff;

   // Sequencer state
   mscan_pkg::mscan_state_e state_ff;
   mscan_pkg::mscan_state_e nxt_state;
   logic [3:0]  cur_ff;
   logic [3:0]  nxt_cur;
   logic        refup_ff;
   logic        nxt_refup;
   logic        conv_ff;
   logic        scan_end_ff;
   logic        manual_ff;
   logic [15:0] wcnt_ff;
   logic [9:0]  us_ff;
   logic [31:0] period_ff;
   logic [31:0] last_period_ff;

   mscan_conv_if cif ();

   mscan_timer u_timer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .cif       (cif)
   );

   // Write decode
   wire wr_setup  = reg_wr_i && reg_addr_i == `MSCAN_A_SETUP;
   wire wr_enable = reg_wr_i && reg_addr_i == `MSCAN_A_ENABLE;
   wire wr_incfg  = reg_wr_i && reg_addr_i == `MSCAN_A_INCFG;
   wire wr_alarm  = reg_wr_i && reg_addr_i == `MSCAN_A_ALARM;
   wire wr_wait   = reg_wr_i && reg_addr_i == `MSCAN_A_WAIT;
   wire wr_chsel  = reg_wr_i && reg_addr_i == `MSCAN_A_CHSEL;
   wire wr_upper  = reg_wr_i && reg_addr_i == `MSCAN_A_UPPER;
   wire wr_lower  = reg_wr_i && reg_addr_i == `MSCAN_A_LOWER;
   wire wr_chcfg  = reg_wr_i && reg_addr_i == `MSCAN_A_CHCFG;

   // Reference mode and per-channel type
   wire [1:0] ref_mode  = setup_ff[`MSCAN_SETUP_REF_HI:`MSCAN_SETUP_REF_LO];
   wire       scan_on   = setup_ff[`MSCAN_SETUP_SCAN];
   wire       long_wait = 32'(wait_ff) * `MSCAN_T_WAIT_UNIT_NS > `MSCAN_T_WAIT_LIM_NS;
   // Shutdown in mode 00, or mode 01 when the wait is long
   wire       auto_sd   = ref_mode == 2'b00 || (ref_mode == 2'b01 && long_wait);
   // Input config: three bits per pair, bit0 temperature, bit1 differential
   wire [1:0] pair_cfg  = (cur_ff >= 4'(`MSCAN_EXT0))
                          ? incfg_ff[3'((cur_ff - 4'(`MSCAN_EXT0)) >> 1) * 3 +: 2] : 2'b00;
   wire       cur_diff  = pair_cfg[1];
   wire       cur_temp  = (cur_ff == 4'h0) || pair_cfg[0];
   wire       cur_odd   = (cur_ff >= 4'(`MSCAN_EXT0)) && cur_ff[0] == 1'b1;

   // Channel is scanned if enabled and not the odd half of a differential pair
   logic [NCH-1:0] live;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_live
         localparam int P = (g - `MSCAN_EXT0) / 2;
         if (g < `MSCAN_EXT0) begin : g_int
            assign live[g] = enable_ff[g];
         end else if ((g - `MSCAN_EXT0) % 2 == 1) begin : g_odd
            assign live[g] = enable_ff[g] && !incfg_ff[P*3+1];
         end else begin : g_even
            assign live[g] = enable_ff[g];
         end
      end
   endgenerate

   // Next live channel in ascending order from cur_ff
   logic [3:0] next_ch;
   logic       next_ok;
   always_comb begin
      next_ch = 4'h0;
      next_ok = 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (live[i] && 4'(i) > cur_ff) begin
            next_ch = 4'(i);
            next_ok = 1'b1;
         end
      end
   end
   // First live channel of a scan: internal temp, supply, then inputs
   logic [3:0] first_ch;
   logic       first_ok;
   always_comb begin
      first_ch = 4'h0;
      first_ok = 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (live[i]) begin
            first_ch = 4'(i);
            first_ok = 1'b1;
         end
      end
   end

   // Coding and compare
   logic [9:0] code;
   logic       over;
   logic       under;
   mscan_code u_code (
      .raw_i   (afe_sample_i),
      .temp_i  (cur_temp),
      .upper_i (upper_ff[cur_ff]),
      .lower_i (lower_ff[cur_ff]),
      .code_o  (code),
      .over_o  (over),
      .under_o (under)
   );

   // Power-up needed before this conversion
   wire need_pu = (ref_mode == 2'b00 && cur_temp) || (ref_mode == 2'b01 && long_wait && !refup_ff);
   wire [15:0] pu_cyc   = (ref_mode == 2'b00) ? 16'(`MSCAN_CYC_PU00) : 16'(`MSCAN_CYC_PU01);
   wire [15:0] conv_cyc = cur_temp ? 16'(`MSCAN_CYC_TEMP) : 16'(`MSCAN_CYC_VOLT);
   wire        wait_end = (wait_ff == 10'h000) || (us_ff == wait_ff);
   wire        sample   = state_ff == mscan_pkg::MSCAN_CONV && cif.done;
   wire        kick     = manual_ff || (scan_on && first_ok);

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cur   = cur_ff;
      nxt_refup = refup_ff;
      cif.start  = 1'b0;
      cif.cycles = conv_cyc;
      case (state_ff)
         mscan_pkg::MSCAN_IDLE: begin
            if (manual_ff) begin
               nxt_cur   = chsel_ff;
               nxt_state = mscan_pkg::MSCAN_PICK;
            end else if (scan_on && first_ok) begin
               nxt_cur   = first_ch;
               nxt_state = mscan_pkg::MSCAN_PICK;
            end
         end
         mscan_pkg::MSCAN_PICK: begin
            cif.start = 1'b1;
            if (need_pu) begin
               cif.cycles = pu_cyc;
               nxt_state  = mscan_pkg::MSCAN_PWUP;
            end else begin
               nxt_state  = mscan_pkg::MSCAN_CONV;
            end
         end
         mscan_pkg::MSCAN_PWUP: begin
            if (cif.done) begin
               cif.start = 1'b1;
               nxt_refup = 1'b1;
               nxt_state = mscan_pkg::MSCAN_CONV;
            end
         end
         mscan_pkg::MSCAN_CONV: begin
            if (cif.done) begin
               if (scan_on && !manual_ff && next_ok) begin
                  nxt_cur   = next_ch;
                  nxt_state = mscan_pkg::MSCAN_PICK;
               end else begin
                  nxt_state = scan_on ? mscan_pkg::MSCAN_WAIT : mscan_pkg::MSCAN_IDLE;
               end
            end
         end
         mscan_pkg::MSCAN_WAIT: begin
            if (wait_end) begin
               nxt_refup = !auto_sd; // Reference powers down across the wait in mode 00, or in mode 01 when the wait is long
               nxt_state = mscan_pkg::MSCAN_IDLE;
            end
         end
         default: nxt_state = mscan_pkg::MSCAN_IDLE;
      endcase
   end

   // Sequencer registers; period counter sums all phases
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_ff  <= mscan_pkg::MSCAN_IDLE;
         cur_ff    <= 4'h0;
         refup_ff  <= 1'b0;
         conv_ff   <= 1'b0;
         manual_ff <= 1'b0;
         wcnt_ff   <= 16'h0000;
         us_ff     <= 10'h000;
         period_ff <= 32'h00000000;
         last_period_ff <= 32'h00000000;
         scan_end_ff    <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         cur_ff    <= nxt_cur;
         refup_ff  <= nxt_refup;
         conv_ff   <= nxt_state == mscan_pkg::MSCAN_CONV;
         manual_ff <= (wr_setup && reg_wdata_i[`MSCAN_SETUP_MANUAL]) ||
                      (manual_ff && state_ff != mscan_pkg::MSCAN_IDLE);
         scan_end_ff <= state_ff == mscan_pkg::MSCAN_WAIT && wait_end;
         // Microsecond tick for the sample wait
         if (state_ff != mscan_pkg::MSCAN_WAIT || wcnt_ff == 16'(`MSCAN_CYC_US - 1))
            wcnt_ff <= 16'h0000;
         else
            wcnt_ff <= wcnt_ff + 16'h0001;
         if (state_ff != mscan_pkg::MSCAN_WAIT)
            us_ff <= 10'h000;
         else if (wcnt_ff == 16'(`MSCAN_CYC_US - 1))
            us_ff <= us_ff + 10'h001;
         // Full scan period from first pick to end of wait
         if (state_ff == mscan_pkg::MSCAN_IDLE && kick)
            period_ff <= 32'h00000001;
         else if (state_ff != mscan_pkg::MSCAN_IDLE)
            period_ff <= period_ff + 32'h00000001;
         if (state_ff == mscan_pkg::MSCAN_WAIT && wait_end)
            last_period_ff <= period_ff;
      end
   end

   // Per-channel registers
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         wire hit = chsel_ff == 4'(g);
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               data_ff[g]  <= `MSCAN_RST_DATA;
               upper_ff[g] <= `MSCAN_RST_UPPER;
               lower_ff[g] <= `MSCAN_RST_LOWER;
               chcfg_ff[g] <= `MSCAN_RST_CHCFG;
            end else begin
               if (sample && cur_ff == 4'(g))
                  data_ff[g] <= code;
               if (wr_upper && hit)
                  upper_ff[g] <= reg_wdata_i[9:0];
               if (wr_lower && hit)
                  lower_ff[g] <= reg_wdata_i[9:0];
               if (wr_chcfg && hit)
                  chcfg_ff[g] <= reg_wdata_i[7:0];
            end
         end
      end
   endgenerate

   // Alarm bits: two per channel, set beats a write-one clear
   wire [23:0] alarm_set = sample ? (24'({over, under}) << {cur_ff, 1'b0}) : 24'h000000;
   wire [23:0] alarm_clr = wr_alarm ? reg_wdata_i[23:0] : 24'h000000;

   // Global registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         setup_ff  <= `MSCAN_RST_SETUP;
         enable_ff <= `MSCAN_RST_ENABLE;
         incfg_ff  <= `MSCAN_RST_INCFG;
         alarm_ff  <= `MSCAN_RST_ALARM;
         wait_ff   <= `MSCAN_RST_WAIT;
         chsel_ff  <= 4'h0;
      end else begin
         if (wr_setup)  setup_ff  <= {reg_wdata_i[7:4], 1'b0, reg_wdata_i[2:0]};
         if (wr_enable) enable_ff <= reg_wdata_i[9:0];
         if (wr_incfg)  incfg_ff  <= reg_wdata_i[11:0];
         if (wr_wait)   wait_ff   <= reg_wdata_i[9:0];
         if (wr_chsel)  chsel_ff  <= reg_wdata_i[3:0];
         alarm_ff <= (alarm_ff & ~alarm_clr) | alarm_set;
      end
   end

   // Read mux, data valid the cycle after the strobe
   logic [31:0] rmux;
   always_comb begin
      case (reg_addr_i)
         `MSCAN_A_SETUP:  rmux = {24'h000000, setup_ff};
         `MSCAN_A_ENABLE: rmux = {22'h000000, enable_ff};
         `MSCAN_A_INCFG:  rmux = {20'h00000, incfg_ff};
         `MSCAN_A_ALARM:  rmux = {8'h00, alarm_ff};
         `MSCAN_A_WAIT:   rmux = {22'h000000, wait_ff};
         `MSCAN_A_STATUS: rmux = {25'h0000000, refup_ff, cur_ff, conv_ff, 1'b0} | 32'(state_ff) << 7;
         `MSCAN_A_CHSEL:  rmux = {28'h0000000, chsel_ff};
         `MSCAN_A_DATA:   rmux = {22'h000000, data_ff[chsel_ff]};
         `MSCAN_A_UPPER:  rmux = {22'h000000, upper_ff[chsel_ff]};
         `MSCAN_A_LOWER:  rmux = {22'h000000, lower_ff[chsel_ff]};
         `MSCAN_A_CHCFG:  rmux = {24'h000000, chcfg_ff[chsel_ff]};
         `MSCAN_A_RESULT: rmux = last_period_ff;
         default:         rmux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) rdata_ff <= 32'h00000000;
      else if (reg_rd_i) rdata_ff <= rmux;
   end

   // Outputs
   assign reg_rdata_o = rdata_ff;
   assign afe_chan_o  = cur_ff;
   assign afe_temp_o  = cur_temp;
   assign afe_diff_o  = cur_diff && !cur_odd;
   assign afe_conv_o  = conv_ff;
   // Reference held up when not in shutdown, or while powering up and converting
   assign ref_on_o    = !auto_sd || state_ff == mscan_pkg::MSCAN_PWUP || conv_ff;
   assign scan_end_o  = scan_end_ff;
   assign alarm_o     = |alarm_ff;

   // Assertions
   a_volt_conv_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == mscan_pkg::MSCAN_PICK && !need_pu && !cur_temp |=>
      conv_ff [*8] ##0 (state_ff == mscan_pkg::MSCAN_CONV))
      else $error("voltage conversion ended early");
   a_mode10_no_pu: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ref_mode == 2'b10 && state_ff == mscan_pkg::MSCAN_PICK |=> state_ff == mscan_pkg::MSCAN_CONV)
      else $error("power-up in reference mode 10");
   a_mode00_temp_pu: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ref_mode == 2'b00 && cur_temp && state_ff == mscan_pkg::MSCAN_PICK |=>
      state_ff == mscan_pkg::MSCAN_PWUP)
      else $error("no power-up before temperature in mode 00");
   a_odd_pair_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_ff == mscan_pkg::MSCAN_PICK && scan_on |-> !(cur_odd && cur_diff))
      else $error("odd half of differential pair scanned");
   a_scan_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sample && nxt_state == mscan_pkg::MSCAN_PICK |=> cur_ff > $past(cur_ff))
      else $error("scan order not ascending");
   a_data_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sample |=> data_ff[$past(cur_ff)] == $past(afe_sample_i))
      else $error("result not stored");
   a_alarm_reset: assert property (@(posedge clk_i)
      sys_rst_i |=> alarm_ff == 24'h000000 && incfg_ff == 12'h000)
      else $error("alarm or input config not cleared");
   a_ref_shutdown: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ref_mode == 2'b00 && state_ff == mscan_pkg::MSCAN_WAIT |-> !ref_on_o)
      else $error("reference on during mode 00 wait");

   c_full_scan: cover property (@(posedge clk_i) scan_end_o);
   c_temp_conv: cover property (@(posedge clk_i) sample && cur_temp);
   c_pwr_up:    cover property (@(posedge clk_i) state_ff == mscan_pkg::MSCAN_PWUP);
   c_alarm:     cover property (@(posedge clk_i) alarm_o);
endmodule : mscan_top

// file: bench/mscan_afe_model.sv
// Analog front end stand-in returning fixed raw codes per channel
`timescale 1ns/1ps
module mscan_afe_model (
   // Clock
   input  wire logic       clk_i,
   // Converter control from the block
   input  wire logic [3:0] chan_i,
   input  wire logic       temp_i,
   input  wire logic       conv_i,
   // Raw code to the block
   output logic [9:0]      sample_o
);
   // Outside a conversion the code toggles, so a stale sample cannot pass
   initial sample_o = 10'h155;
   always @(posedge clk_i) begin
      if (conv_i) begin
         sample_o <= temp_i ? 10'h032 : (10'h100 + {6'h00, chan_i});
      end else begin
         sample_o <= ~sample_o;
      end
   end
endmodule : mscan_afe_model

// file: bench/mscan_top_tb.sv
// Self-checking bench for the monitor scan timing block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module mscan_top_tb;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [9:0]  afe_sample_i;
   logic [3:0]  afe_chan_o;
   logic        afe_temp_o, afe_diff_o, afe_conv_o, ref_on_o, scan_end_o, alarm_o;
   int          fails = 0;
   int          n_compared = 0;
   logic [3:0]  cap_chan;
   logic        cap_temp;
   int          len, pre;

   mscan_top i_mscan_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .afe_sample_i(afe_sample_i), .afe_chan_o(afe_chan_o),
      .afe_temp_o(afe_temp_o), .afe_diff_o(afe_diff_o), .afe_conv_o(afe_conv_o),
      .ref_on_o(ref_on_o), .scan_end_o(scan_end_o), .alarm_o(alarm_o));
   mscan_afe_model i_mscan_afe_model (.clk_i(clk_i), .chan_i(afe_chan_o),
      .temp_i(afe_temp_o), .conv_i(afe_conv_o), .sample_o(afe_sample_i));

   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic do_reset();
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
   endtask : do_reset

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   // Read data is looked at only in the cycle after the read edge
   task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(nm, e, reg_rdata_o)
   endtask : rchk

   // Bounded wait for a conversion; counts reference-on cycles before it
   task automatic wait_conv();
      len = 0;
      pre = 0;
      for (int i = 0; i < 3000 && afe_conv_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
         if (ref_on_o === 1'b1 && afe_conv_o !== 1'b1) pre++;
      end
      cap_chan = afe_chan_o;
      cap_temp = afe_temp_o;
      while (afe_conv_o === 1'b1 && len < 3000) begin
         @(posedge clk_i);
         #1;
         len++;
      end
   endtask : wait_conv

   task automatic t_defaults();
      rchk(4'h2, 32'h0, "incfg");
      rchk(4'h3, 32'h0, "alarm");
      rchk(4'hc, 32'h0, "unmapped");
      for (int c = 0; c < 10; c++) begin
         wr(4'h6, c);
         rchk(4'h7, 32'h200, "data");
         rchk(4'h8, 32'h3ff, "upper");
         rchk(4'h9, 32'h000, "lower");
         rchk(4'ha, 32'h000, "chcfg");
      end
      $display("test defaults done");
   endtask : t_defaults

   // Manual voltage conversion, mode 10, then over-range alarm and clear
   task automatic t_volt_alarm();
      wr(4'h6, 32'h2);
      wr(4'h8, 32'h050);
      wr(4'h0, 32'h00c);
      wait_conv();
      `CHK("volt_len", 265, len)
      `CHK("volt_temp", 1'b0, cap_temp)
      repeat (2) @(posedge clk_i);
      rchk(4'h7, 32'h102, "volt_data");
      rchk(4'h3, 32'h20, "alarm_set");
      `CHK("alarm_o", 1'b1, alarm_o)
      wr(4'h3, 32'h20);
      rchk(4'h3, 32'h0, "alarm_clr");
      `CHK("alarm_o_clr", 1'b0, alarm_o)
      $display("test volt_alarm done");
   endtask : t_volt_alarm

   // Single-ended temperature on the first external input, mode 10
   task automatic t_temp();
      wr(4'h2, 32'h001);
      wr(4'h1, 32'h004);
      `CHK("ref_on_m10", 1'b1, ref_on_o)
      wr(4'h0, 32'h00c);
      wait_conv();
      `CHK("temp_len", 1150, len)
      `CHK("temp_flag", 1'b1, cap_temp)
      repeat (2) @(posedge clk_i);
      rchk(4'h7, 32'h032, "temp_data");
      $display("test temp done");
   endtask : t_temp

   // Mode 00: reference off when idle, 20 us power-up before temperature
   task automatic t_refup();
      wr(4'h6, 32'h0);
      wr(4'h0, 32'h000);
      repeat (2) @(posedge clk_i);
      `CHK("ref_off_idle", 1'b0, ref_on_o)
      wr(4'h0, 32'h008);
      wait_conv();
      `CHK("pu00", 1'b1, (pre >= 500 && pre <= 503))
      `CHK("pu_chan", 4'h0, cap_chan)
      `CHK("pu_len", 1150, len)
      rchk(4'h3, 32'h0, "temp_no_alarm");
      $display("test refup done");
   endtask : t_refup

   // Mode 00 scan with a differential pair: odd member skipped, period summed
   task automatic t_scan();
      int         n;
      int         per;
      logic       prev;
      logic       dif;
      logic [3:0] chs [2];
      n = 0;
      per = 0;
      prev = 1'b0;
      dif = 1'b0;
      wr(4'h2, 32'h002);
      wr(4'h1, 32'h00d);
      wr(4'h4, 32'h002);
      wr(4'h0, 32'h001);
      for (int i = 0; i < 6000 && scan_end_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      // Period from one scan-end pulse to the next
      do begin
         @(posedge clk_i);
         #1;
         per++;
         if (afe_conv_o === 1'b1 && !prev) begin
            if (n < 2) chs[n] = afe_chan_o;
            if (afe_chan_o === 4'h2) dif = afe_diff_o;
            n++;
         end
         prev = afe_conv_o;
      end while (scan_end_o !== 1'b1 && per < 6000);
      `CHK("scan_n", 2, n)
      `CHK("scan_c0", 4'h0, chs[0])
      `CHK("scan_c1", 4'h2, chs[1])
      `CHK("scan_diff", 1'b1, dif)
      `CHK("scan_per", 1'b1, (per >= 1965 && per <= 1980))
      $display("test scan done");
   endtask : t_scan

   // Mode 01, wait over 80 us: one 40 us power-up per scan; pair 0 differential temperature
   task automatic t_mode01();
      wr(4'h2, 32'h003);
      wr(4'h1, 32'h005);
      wr(4'h4, 32'h051);
      wr(4'h0, 32'h003);
      for (int i = 0; i < 9000 && scan_end_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      wait_conv();
      `CHK("pu01", 1000, pre)
      `CHK("pu01_chan", 4'h0, cap_chan)
      wait_conv();
      `CHK("pu01_once", 0, pre)
      `CHK("dtemp_chan", 4'h2, cap_chan)
      `CHK("dtemp_temp", 1'b1, cap_temp)
      `CHK("dtemp_len", 1150, len)
      `CHK("dtemp_diff", 1'b1, afe_diff_o)
      $display("test mode01 done");
   endtask : t_mode01

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Main sequence; a second reset mid-run must restore the input config, alarm, data, threshold and channel config defaults
   initial begin
      do_reset();
      t_defaults();
      t_volt_alarm();
      t_temp();
      t_refup();
      t_scan();
      t_mode01();
      @(posedge clk_i);
      do_reset();
      t_defaults();
      print_verdict();
   end

   // Watchdog well beyond the expected run of about 15500 cycles
   initial begin
      #(40 * 60000);
      fails++;
      print_verdict();
   end
endmodule : mscan_top_tb
